// [acf_cfg.svh]
// Constants of the converter configuration and result formatting block.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef ACF_CFG_SVH
`define ACF_CFG_SVH

// ****************************************************************
// Register addresses in the special-function register space
// ****************************************************************
`define ACF_ADDR_CONFIG      8'hBC
`define ACF_ADDR_RESULT_LOW  8'hBD
`define ACF_ADDR_RESULT_HIGH 8'hBE

// ****************************************************************
// Field positions of the configuration register
// ****************************************************************
`define ACF_DIV_MSB   7
`define ACF_DIV_LSB   3
`define ACF_LJST_BIT  2
`define ACF_EIGHT_BIT 1
`define ACF_GAIN_BIT  0

// ****************************************************************
// Reset values
// ****************************************************************
`define ACF_CONFIG_RESET 8'hF8
`define ACF_RESULT_RESET 8'h00

// ****************************************************************
// Conversion length in converter clock cycles
// ****************************************************************
`define ACF_CONV_CYCLES_10 5'h0B
`define ACF_CONV_SHORTEN_8 5'h02

`endif

// [acf_pkg.sv]
// Types shared by the converter configuration block, the core model and the bench.
// Assumes acf_cfg.svh is reachable on the include path.
`default_nettype none
`include "acf_cfg.svh"
package acf_pkg;
    typedef logic [7:0] acf_byte_t;
    typedef logic [9:0] acf_code_t;
    typedef enum logic [1:0] {ACF_IDLE, ACF_CONVERT, ACF_DONE} acf_state_t;
endpackage : acf_pkg
`default_nettype wire

// [acf_clk_div.sv]
// Converter clock enable divider: one-cycle pulse every divisor+1 system clocks.
// Assumes a single system clock; the divisor may change at any time.
`default_nettype none
`include "acf_cfg.svh"
module acf_clk_div #(
    parameter int DIV_W = 5
) (
    input wire logic sys_clk_i,              // System clock
    input wire logic reset_n_i,              // Synchronous reset, active low
    input wire logic [DIV_W-1:0] divisor_i,  // Divide by divisor+1
    output logic conv_tick_o                 // Converter clock enable pulse
);
    logic [DIV_W-1:0] count;
    logic [DIV_W-1:0] next_count;

    if (DIV_W < 1) begin : g_bad_width
        $error("acf_clk_div: DIV_W must be at least 1");
    end

    always_comb begin
        // Counting up to the divisor gives a period of divisor+1
        if (count >= divisor_i) begin
            next_count = '0;
        end else begin
            next_count = count + {{(DIV_W-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

    assign conv_tick_o = (count >= divisor_i);

    chk_tick_period: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        (conv_tick_o && $stable(divisor_i)) |=> ((count == '0) && (divisor_i == '0 || !conv_tick_o)))
        else $error("divider did not restart after tick");
endmodule : acf_clk_div
`default_nettype wire

// [acf_converter_ctrl.sv]
// Configuration and result registers of a 10-bit successive-approximation converter.
// Assumes an SFR bus with one-cycle read and write strobes and a core giving one code per conversion.
`default_nettype none
`include "acf_cfg.svh"

// What this block does
// - The converter clock enable is the system clock divided by the 5-bit divisor in bits 7:3 plus one.
// - Bit 2 selects right (0) or left (1) justification of the result.
// - Bit 1 selects 10-bit (0) or 8-bit (1) conversion.
// - Justification only matters in 10-bit mode.
// - Bit 0 drives the gain: 0 is half gain, 1 is unity gain.
// - Right-justified 10-bit high byte holds zeros in 7:2 and the top two bits in 1:0.
// - Left-justified 10-bit high byte holds the eight top bits.
// - In 8-bit mode the high byte holds the whole 8-bit result.
// - Right-justified 10-bit low byte holds the eight low bits.
// - Left-justified 10-bit low byte holds the two low bits in 7:6 and zeros below.
// - In 8-bit mode the low byte reads zero.
// - Both result bytes update at the end of every conversion.
// - An 8-bit conversion takes two converter clocks fewer than a 10-bit one.
module acf_converter_ctrl #(
    parameter int DIV_W = 5
) (
    input wire logic sys_clk_i,               // System clock, 100 MHz
    input wire logic reset_n_i,               // Synchronous reset, active low
    input wire logic [7:0] sfr_addr_i,        // SFR address
    input wire logic sfr_wr_i,                // Write strobe, one cycle
    input wire logic sfr_rd_i,                // Read strobe, one cycle
    input wire acf_pkg::acf_byte_t sfr_wdata_i, // Write data
    output var acf_pkg::acf_byte_t sfr_rdata_o, // Read data, registered
    output logic sfr_hit_o,                   // Address belongs to this block
    input wire logic conv_start_i,            // Start a conversion, one-cycle pulse
    input wire acf_pkg::acf_code_t core_code_i, // Code from the core at end of conversion
    output logic conv_tick_o,                 // Converter clock enable
    output logic gain_unity_o,                // 1 unity gain, 0 half gain
    output logic eight_bit_o,                 // Core runs 8-bit conversion
    output logic conv_busy_o,                 // Conversion in progress
    output logic conv_done_o                  // One-cycle pulse when results load
);
    import acf_pkg::*;

    if (DIV_W != (`ACF_DIV_MSB - `ACF_DIV_LSB + 1)) begin : g_bad_width
        $error("acf_converter_ctrl: DIV_W must match field");
    end

    // ****************************************************************
    // Formatting
    // ****************************************************************
    function automatic logic [15:0] fmt_result(input acf_code_t code, input logic ljst, input logic eight);
        if (eight) begin
            fmt_result = {code[9:2], 8'h00};
        end else if (ljst) begin
            fmt_result = {code, 6'h00};
        end else begin
            fmt_result = {6'h00, code};
        end
    endfunction

    // ****************************************************************
    // Registers
    // ****************************************************************
    acf_byte_t config_reg, next_config_reg;
    acf_byte_t result_low, next_result_low;
    acf_byte_t result_high, next_result_high;
    acf_byte_t rdata, next_rdata;
    acf_state_t state, next_state;
    logic [4:0] cycles, next_cycles;
    logic done, next_done;
    logic tick;
    logic [15:0] formatted;

    wire logic ljst = config_reg[`ACF_LJST_BIT];
    wire logic eight = config_reg[`ACF_EIGHT_BIT];
    // Mode is read live: changing it mid-conversion alters the length of that conversion
    wire logic [4:0] conv_len = eight ? (`ACF_CONV_CYCLES_10 - `ACF_CONV_SHORTEN_8) : `ACF_CONV_CYCLES_10;

    acf_clk_div #(.DIV_W(DIV_W)) u_div (
        .sys_clk_i(sys_clk_i),
        .reset_n_i(reset_n_i),
        .divisor_i(config_reg[`ACF_DIV_MSB:`ACF_DIV_LSB]),
        .conv_tick_o(tick)
    );

    assign formatted = fmt_result(core_code_i, ljst, eight);

    // ****************************************************************
    // Conversion sequencing
    // ****************************************************************
    always_comb begin
        next_state = state;
        next_cycles = cycles;
        next_done = 1'b0;
        unique case (state)
            ACF_IDLE: begin
                if (conv_start_i) begin
                    next_state = ACF_CONVERT;
                    next_cycles = '0;
                end
            end
            ACF_CONVERT: begin
                if (tick) begin
                    if (cycles + 5'h01 >= conv_len) begin
                        next_state = ACF_DONE;
                    end
                    next_cycles = cycles + 5'h01;
                end
            end
            ACF_DONE: begin
                next_done = 1'b1;
                next_state = ACF_IDLE;
            end
        endcase
    end

    // Core results take priority over a same-cycle software write to a result byte
    always_comb begin
        next_config_reg = config_reg;
        next_result_low = result_low;
        next_result_high = result_high;
        next_rdata = rdata;
        if (sfr_wr_i) begin
            if (sfr_addr_i == `ACF_ADDR_CONFIG) next_config_reg = sfr_wdata_i;
            if (sfr_addr_i == `ACF_ADDR_RESULT_LOW) next_result_low = sfr_wdata_i;
            if (sfr_addr_i == `ACF_ADDR_RESULT_HIGH) next_result_high = sfr_wdata_i;
        end
        if (state == ACF_DONE) begin
            next_result_high = formatted[15:8];
            next_result_low = formatted[7:0];
        end
        if (sfr_rd_i) begin
            if (sfr_addr_i == `ACF_ADDR_CONFIG) next_rdata = config_reg;
            else if (sfr_addr_i == `ACF_ADDR_RESULT_LOW) next_rdata = result_low;
            else if (sfr_addr_i == `ACF_ADDR_RESULT_HIGH) next_rdata = result_high;
            else next_rdata = 8'h00;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            config_reg <= `ACF_CONFIG_RESET;
            result_low <= `ACF_RESULT_RESET;
            result_high <= `ACF_RESULT_RESET;
            rdata <= `ACF_RESULT_RESET;
            state <= ACF_IDLE;
            cycles <= '0;
            done <= 1'b0;
        end else begin
            config_reg <= next_config_reg;
            result_low <= next_result_low;
            result_high <= next_result_high;
            rdata <= next_rdata;
            state <= next_state;
            cycles <= next_cycles;
            done <= next_done;
        end
    end

    assign sfr_rdata_o = rdata;
    assign sfr_hit_o = (sfr_addr_i == `ACF_ADDR_CONFIG) || (sfr_addr_i == `ACF_ADDR_RESULT_LOW)
                       || (sfr_addr_i == `ACF_ADDR_RESULT_HIGH);
    assign conv_tick_o = tick;
    assign gain_unity_o = config_reg[`ACF_GAIN_BIT];
    assign eight_bit_o = eight;
    assign conv_busy_o = (state != ACF_IDLE);
    assign conv_done_o = done;

    // ****************************************************************
    // Checks
    // ****************************************************************
    sequence s_finish;
        state == ACF_DONE;
    endsequence

    // One converter clock of an active conversion
    sequence s_step;
        state == ACF_CONVERT && tick;
    endsequence

    // Outside a completion only software may move the result bytes
    chk_result_hold: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        (state != ACF_DONE && !sfr_wr_i) |=> ($stable(result_high) && $stable(result_low)))
        else $error("result bytes moved outside a completion");
    chk_eight_ignore_ljst: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        (s_finish and eight && ljst) |=> (result_high == $past(core_code_i[9:2]) && result_low == 8'h00))
        else $error("justification used in 8-bit mode");

    chk_eight_low_zero: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        (s_finish and eight) |=> (result_low == 8'h00))
        else $error("low byte not zero in 8-bit mode");
    chk_eight_high_data: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        (s_finish and eight) |=> (result_high == $past(core_code_i[9:2])))
        else $error("high byte wrong in 8-bit mode");
    chk_right_high_fill: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        (s_finish and !eight && !ljst) |=> (result_high == {6'h00, $past(core_code_i[9:8])}))
        else $error("right-justified high byte wrong");
    chk_right_low_data: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        (s_finish and !eight && !ljst) |=> (result_low == $past(core_code_i[7:0])))
        else $error("right-justified low byte wrong");
    chk_left_high_data: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        (s_finish and !eight && ljst) |=> (result_high == $past(core_code_i[9:2])))
        else $error("left-justified high byte wrong");
    chk_left_low_fill: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        (s_finish and !eight && ljst) |=> (result_low == {$past(core_code_i[1:0]), 6'h00}))
        else $error("left-justified low byte wrong");
    chk_done_pulse: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        s_finish |=> (conv_done_o ##1 !conv_done_o))
        else $error("done pulse missing or long");
    chk_gain_follow: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        (sfr_wr_i && sfr_addr_i == `ACF_ADDR_CONFIG) |=> (gain_unity_o == $past(sfr_wdata_i[`ACF_GAIN_BIT])))
        else $error("gain does not follow config");
    chk_mode_follow: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        (sfr_wr_i && sfr_addr_i == `ACF_ADDR_CONFIG) |=> (eight_bit_o == $past(sfr_wdata_i[`ACF_EIGHT_BIT])))
        else $error("resolution does not follow config");
    chk_short_conv: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        (s_step and eight && cycles == (`ACF_CONV_CYCLES_10 - `ACF_CONV_SHORTEN_8 - 5'h01)) |=> s_finish)
        else $error("8-bit conversion length wrong");
    chk_long_conv: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        (s_step and !eight && cycles == (`ACF_CONV_CYCLES_10 - 5'h01)) |=> s_finish)
        else $error("10-bit conversion length wrong");

    // A conversion only advances on the converter clock
    chk_convert_wait: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        (state == ACF_CONVERT && !tick) |=> (state == ACF_CONVERT && $stable(cycles)))
        else $error("conversion advanced without converter clock");
endmodule : acf_converter_ctrl
`default_nettype wire

// [acf_core_model.sv]
// Behavioural model of the analogue converter core feeding the result code.
// Assumes the block samples the code only while its busy output is high.
`default_nettype none
module acf_core_model (
    input wire logic sys_clk_i,               // System clock
    input wire logic busy_i,                  // Conversion in progress
    input wire acf_pkg::acf_code_t code_i,    // Code this conversion yields
    output var acf_pkg::acf_code_t core_code_o // Code seen by the block
);
    timeunit 1ns;
    timeprecision 1ps;
    import acf_pkg::*;
    acf_code_t last;
    always_ff @(posedge sys_clk_i) begin
        last <= core_code_o;
    end
    // Not held outside a conversion: toggle so a stale sample shows up
    assign core_code_o = busy_i ? code_i : ~last;
endmodule // acf_core_model
`default_nettype wire

// [testbench.sv]
// Self-checking bench of the converter configuration and result block.
// Assumes acf_pkg, acf_cfg.svh and acf_core_model are compiled first.
`default_nettype none
`include "acf_cfg.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import acf_pkg::*;
    logic sys_clk = 0, reset_n = 0, wr = 0, rd = 0, start = 0;
    logic [7:0] addr = 8'h00;
    acf_byte_t wdata = 8'h00, rdata;
    acf_code_t code = 10'h000, core_code;
    logic hit, tick, gain, eight, busy, done;
    int fail_count = 0, checks = 0, cyc = 0;
    acf_converter_ctrl uut (.sys_clk_i(sys_clk), .reset_n_i(reset_n), .sfr_addr_i(addr),
        .sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_wdata_i(wdata), .sfr_rdata_o(rdata),
        .sfr_hit_o(hit), .conv_start_i(start), .core_code_i(core_code), .conv_tick_o(tick),
        .gain_unity_o(gain), .eight_bit_o(eight), .conv_busy_o(busy), .conv_done_o(done));
    acf_core_model core (.sys_clk_i(sys_clk), .busy_i(busy), .code_i(code), .core_code_o(core_code));
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            test_done();
        end
    end
    task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One access; ends a cycle later so strobes never toggle twice in a step
    task automatic sfr(logic w, logic [7:0] a, acf_byte_t d, output acf_byte_t q);
        logic mapped;
        mapped = a inside {`ACF_ADDR_CONFIG, `ACF_ADDR_RESULT_LOW, `ACF_ADDR_RESULT_HIGH};
        addr = a;
        wdata = d;
        wr = w;
        rd = !w;
        #1 chk("hit", {15'h0000, mapped}, {15'h0000, hit});
        @(posedge sys_clk);
        #1 wr = 0;
        rd = 0;
        q = rdata;
        @(posedge sys_clk);
        #1;
    endtask
    // Waits for done (on_done set) or for the converter clock enable; running out is a mismatch
    task automatic step_until(input bit on_done, input int lim, output int n);
        n = 0;
        do begin
            @(posedge sys_clk);
            #1 n++;
        end while ((on_done ? done : tick) !== 1'b1 && n < lim);
        if ((on_done ? done : tick) !== 1'b1) begin
            fail_count++;
            $display("mismatch %s expected 1 seen %b", on_done ? "done" : "tick", on_done ? done : tick);
        end
    endtask
    task automatic convert(acf_code_t c, output int n);
        code = c;
        start = 1;
        @(posedge sys_clk);
        #1 start = 0;
        chk("busy", 16'h0001, {15'h0000, busy});
        step_until(1, 2000, n);
        chk("busy after done", 16'h0000, {15'h0000, busy});
        @(posedge sys_clk);
        #1 chk("done pulse", 16'h0000, {15'h0000, done});
    endtask
    // Expected {high, low} for mode {eight_bit, left_justify}
    function automatic logic [15:0] fmt(logic [1:0] m, acf_code_t c);
        if (m[1]) return {c[9:2], 8'h00};
        if (m[0]) return {c[9:2], c[1:0], 6'h00};
        return {6'h00, c};
    endfunction
    initial begin
        acf_byte_t q, cfg;
        acf_code_t c;
        int n, n10;
        int divs[4];
        logic [1:0] m;
        void'($urandom(13288));
        repeat (10) @(posedge sys_clk);
        #1 reset_n = 1;
        // ****************************************************************
        // Reset values, unmapped address, high result byte writable
        // ****************************************************************
        sfr(0, `ACF_ADDR_CONFIG, 8'h00, q);
        chk("config reset", 16'h00F8, {8'h00, q});
        chk("gain reset", 16'h0000, {15'h0000, gain});
        for (int i = 0; i < 3; i++) begin
            sfr(0, 8'hBD + 8'(i), 8'h00, q);
            chk("result or unmapped reset", 16'h0000, {8'h00, q});
        end
        sfr(1, 8'hBF, 8'h5A, q);
        sfr(0, `ACF_ADDR_CONFIG, 8'h00, q);
        chk("config after unmapped write", 16'h00F8, {8'h00, q});
        sfr(1, `ACF_ADDR_RESULT_HIGH, 8'hA5, q);
        sfr(0, `ACF_ADDR_RESULT_HIGH, 8'h00, q);
        chk("high byte write", 16'h00A5, {8'h00, q});
        $display("test reset done");
        // ****************************************************************
        // Converter clock period is divisor plus one
        // ****************************************************************
        divs = '{0, 1, 31, $urandom_range(2, 30)};
        foreach (divs[i]) begin
            sfr(1, `ACF_ADDR_CONFIG, 8'(divs[i] << 3), q);
            step_until(0, 40, n);
            step_until(0, 40, n);
            chk("tick period", 16'(divs[i] + 1), 16'(n));
        end
        $display("test divider done");
        // ****************************************************************
        // Result placement in every mode, corner and random codes
        // ****************************************************************
        for (int i = 0; i < 16; i++) begin
            m = i[1:0];
            c = (i < 4) ? 10'h3FF : ((i < 8) ? 10'h201 : 10'($urandom));
            cfg = {5'($urandom_range(0, 3)), m[0], m[1], 1'($urandom)};
            sfr(1, `ACF_ADDR_CONFIG, cfg, q);
            chk("gain", {15'h0000, cfg[0]}, {15'h0000, gain});
            chk("eight bit", {15'h0000, cfg[1]}, {15'h0000, eight});
            convert(c, n);
            sfr(0, `ACF_ADDR_RESULT_HIGH, 8'h00, q);
            chk("high byte", fmt(m, c) >> 8, {8'h00, q});
            sfr(0, `ACF_ADDR_RESULT_LOW, 8'h00, q);
            chk("low byte", fmt(m, c) & 16'h00FF, {8'h00, q});
        end
        $display("test formatting done");
        // ****************************************************************
        // Eight-bit conversion is two converter clocks shorter
        // ****************************************************************
        sfr(1, `ACF_ADDR_CONFIG, 8'h00, q);
        convert(10'h155, n10);
        sfr(1, `ACF_ADDR_CONFIG, 8'h02, q);
        convert(10'h2AA, n);
        chk("eight bit length", 16'(n10 - 2), 16'(n));
        $display("test length done");
        test_done();
    end
endmodule // testbench
`default_nettype wire
